// *** hw/qp_pkg.sv ***
// Shared constants of the quad potentiometer wiper controller.
// Assumes a 200 MHz system clock and 32-bit AXI4-Lite register access.
package qp_pkg;
  localparam int unsigned CLK_MHZ           = 200;
  // Glitch suppression width and non-volatile write cycle time
  localparam int unsigned GLITCH_REJECT_NS  = 50;
  localparam int unsigned GLITCH_CYCLES     = (GLITCH_REJECT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NV_WRITE_CYCLE_MS = 20;
  localparam int unsigned NV_WRITE_CYCLES   = NV_WRITE_CYCLE_MS * CLK_MHZ * 1000;
  localparam int unsigned RECALL_CYCLES     = 16;
  // Bus identity nibble, value is arbitrary
  localparam logic [3:0]  BUS_ID_NIBBLE     = 4'h5;

  localparam int unsigned NUM_POTS          = 4;
  localparam int unsigned TAP_W             = 7;
  localparam logic [6:0]  WIPER_RESET       = 7'h40;
  localparam logic [6:0]  STORE_INIT        = 7'h40;

  // Serial register addresses and access control bit positions
  localparam logic [7:0]  SER_ACR_ADDR      = 8'h08;
  localparam int unsigned ACR_VOL_BIT       = 7;
  localparam int unsigned ACR_PDN_BIT       = 6;
  localparam int unsigned ACR_WIP_BIT       = 5;
  localparam logic        ACR_VOL_RESET     = 1'b0;
  localparam logic        ACR_PDN_RESET     = 1'b1;

  // AXI4-Lite byte offsets
  localparam int unsigned AXI_ADDR_W        = 8;
  localparam logic [7:0]  OFS_WIPER0        = 8'h00;
  localparam logic [7:0]  OFS_STORE0        = 8'h10;
  localparam logic [7:0]  OFS_STATUS        = 8'h20;
  localparam logic [7:0]  OFS_CTRL          = 8'h24;
  localparam int unsigned ST_WIP_BIT        = 0;
  localparam int unsigned ST_PDN_BIT        = 1;
  localparam int unsigned ST_RECALL_BIT     = 2;
  localparam int unsigned ST_ACR_LSB        = 8;
  localparam int unsigned CTRL_EN_BIT       = 0;
  localparam logic        CTRL_EN_RESET     = 1'b1;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEV_ADR = 4'h1,
    ST_ACK_DEV = 4'h3,
    ST_REG_ADR = 4'h2,
    ST_ACK_REG = 4'h6,
    ST_WR_DATA = 4'h7,
    ST_ACK_WR  = 4'h5,
    ST_RD_DATA = 4'h4,
    ST_RD_ACK  = 4'hC
  } qp_state_t;
endpackage

// *** hw/qp_glitch_filter.sv ***
// Pulse suppression filter for one serial bus line.
// Assumes the input is already synchronous to CLK.
`timescale 1ns/1ps
module qp_glitch_filter #(
  parameter int unsigned STABLE_CYCLES = qp_pkg::GLITCH_CYCLES
) (
  input  wire logic CLK,   // System clock
  input  wire logic RST,   // Synchronous reset
  input  wire logic LINE,  // Raw line level
  output logic      LEVEL  // Filtered line level
);
  localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
  logic [CW-1:0] cnt;

  // Level only follows after the line has differed for the full width
  always_ff @(posedge CLK) begin
    if (RST) begin
      LEVEL <= 1'b1;
      cnt   <= '0;
    end else if (LINE == LEVEL) begin
      cnt <= '0;
    end else if (cnt == CW'(STABLE_CYCLES - 1)) begin
      LEVEL <= LINE;
      cnt   <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end
endmodule

// *** hw/qp_wiper_ctrl.sv ***
// Digital control of a quad potentiometer: serial bus slave, wiper and
// initial store registers, power-down, self-timed store write, AXI4-Lite view.
// Assumes serial lines and straps are synchronous to CLK; RST acts as power-up.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module qp_wiper_ctrl #(
  parameter int unsigned NV_WRITE_CYCLES = qp_pkg::NV_WRITE_CYCLES,
  parameter int unsigned RECALL_CYCLES   = qp_pkg::RECALL_CYCLES,
  parameter int unsigned GLITCH_CYCLES   = qp_pkg::GLITCH_CYCLES,
  parameter logic [3:0]  BUS_ID_NIBBLE   = qp_pkg::BUS_ID_NIBBLE
) (
  input  wire logic        CLK,                   // System clock
  input  wire logic        RST,                   // Synchronous reset, power-up
  input  wire logic        SCL_I,                 // Serial clock line
  input  wire logic        SDA_I,                 // Serial data line level
  output logic             SDA_O,                 // Serial data drive value
  output logic             SDA_OE_N,              // Low while pulling data low
  input  wire logic [2:0]  BUS_ADDR_STRAPS,       // Address strap pins
  input  wire logic        POWER_DOWN_CONTROL_N,  // Power-down pin, low active
  output logic [27:0]      WIPER_TAP,             // Tap select, 7 bits per pot
  output logic [3:0]       HIGH_TERMINAL_OPEN,    // High end disconnected
  output logic [3:0]       WIPER_TO_LOW,          // Wiper tied to low terminal
  input  wire logic [7:0]  S_AXI_AWADDR,          // Write address
  input  wire logic        S_AXI_AWVALID,         // Write address valid
  output logic             S_AXI_AWREADY,         // Write address ready
  input  wire logic [31:0] S_AXI_WDATA,           // Write data
  input  wire logic [3:0]  S_AXI_WSTRB,           // Write byte strobes
  input  wire logic        S_AXI_WVALID,          // Write data valid
  output logic             S_AXI_WREADY,          // Write data ready
  output logic [1:0]       S_AXI_BRESP,           // Write response
  output logic             S_AXI_BVALID,          // Write response valid
  input  wire logic        S_AXI_BREADY,          // Write response ready
  input  wire logic [7:0]  S_AXI_ARADDR,          // Read address
  input  wire logic        S_AXI_ARVALID,         // Read address valid
  output logic             S_AXI_ARREADY,         // Read address ready
  output logic [31:0]      S_AXI_RDATA,           // Read data
  output logic [1:0]       S_AXI_RRESP,           // Read response
  output logic             S_AXI_RVALID,          // Read response valid
  input  wire logic        S_AXI_RREADY           // Read response ready
);
  localparam int unsigned NVW = $clog2(NV_WRITE_CYCLES + 1);
  localparam int unsigned RCW = $clog2(RECALL_CYCLES + 1);

  qp_pkg::qp_state_t state;
  logic [6:0]     wiper [qp_pkg::NUM_POTS];
  logic [6:0]     store [qp_pkg::NUM_POTS];
  logic           scl_f;
  logic           sda_f;
  logic           scl_q;
  logic           sda_q;
  logic [7:0]     shreg;
  logic [3:0]     bitcnt;
  logic [7:0]     ptr;
  logic [7:0]     out_byte;
  logic           rw;
  logic           master_nack;
  logic           volatile_target_select;
  logic           pdn_bit;
  logic           nv_write_pending;
  logic           nv_dirty;
  logic [NVW-1:0] nv_cnt;
  logic [RCW-1:0] recall_cnt;
  logic           recall_done;
  logic           ser_en;
  logic           pdn_active;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_ev;
  logic           stop_ev;
  logic           byte_done;
  logic           dev_match;
  logic           wr_ev;
  logic           wr_wiper_ok;
  logic           wr_acr_ok;
  logic           recall_pulse;
  logic [7:0]     rd_byte;
  logic           axi_wr;
  logic           axi_rd;
  logic [31:0]    status_word;

  qp_glitch_filter #(.STABLE_CYCLES(GLITCH_CYCLES)) u_scl_filt (
    .CLK   (CLK),
    .RST   (RST),
    .LINE  (SCL_I),
    .LEVEL (scl_f)
  );

  qp_glitch_filter #(.STABLE_CYCLES(GLITCH_CYCLES)) u_sda_filt (
    .CLK   (CLK),
    .RST   (RST),
    .LINE  (SDA_I),
    .LEVEL (sda_f)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign scl_rise  = scl_f & ~scl_q;
  assign scl_fall  = ~scl_f & scl_q;
  assign start_ev  = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_ev   = scl_f & scl_q & ~sda_q & sda_f;
  assign byte_done = scl_fall & (bitcnt == 4'h8);
  assign dev_match = (shreg[7:1] == {BUS_ID_NIBBLE, BUS_ADDR_STRAPS});
  assign wr_ev     = byte_done & (state == qp_pkg::ST_WR_DATA);
  // Pending store write locks out wiper and control writes
  assign wr_wiper_ok = wr_ev & (ptr < 8'(qp_pkg::NUM_POTS)) & ~nv_write_pending;
  assign wr_acr_ok   = wr_ev & (ptr == qp_pkg::SER_ACR_ADDR) & ~nv_write_pending;
  assign pdn_active  = ~(POWER_DOWN_CONTROL_N & pdn_bit);

  // Readback byte; other addresses read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (ptr < 8'(qp_pkg::NUM_POTS)) begin
      rd_byte = {1'b0, volatile_target_select ? wiper[ptr[1:0]] : store[ptr[1:0]]};
    end else if (ptr == qp_pkg::SER_ACR_ADDR) begin
      rd_byte = {volatile_target_select, pdn_bit, nv_write_pending, 5'h00};
    end
  end

  // Serial slave sequencing; power-down does not stop it
  always_ff @(posedge CLK) begin
    if (RST) begin
      state       <= qp_pkg::ST_IDLE;
      shreg       <= 8'h00;
      bitcnt      <= 4'h0;
      ptr         <= 8'h00;
      out_byte    <= 8'h00;
      rw          <= 1'b0;
      master_nack <= 1'b0;
      SDA_OE_N    <= 1'b1;
    end else if (!recall_done || !ser_en) begin
      state    <= qp_pkg::ST_IDLE;
      SDA_OE_N <= 1'b1;
    end else if (start_ev) begin
      state    <= qp_pkg::ST_DEV_ADR;
      bitcnt   <= 4'h0;
      SDA_OE_N <= 1'b1;
    end else if (stop_ev) begin
      state    <= qp_pkg::ST_IDLE;
      SDA_OE_N <= 1'b1;
    end else if (scl_rise) begin
      case (state)
        qp_pkg::ST_DEV_ADR, qp_pkg::ST_REG_ADR, qp_pkg::ST_WR_DATA: begin
          shreg  <= {shreg[6:0], sda_f};
          bitcnt <= bitcnt + 4'h1;
        end
        qp_pkg::ST_RD_DATA: begin
          bitcnt <= bitcnt + 4'h1;
        end
        qp_pkg::ST_RD_ACK: begin
          master_nack <= sda_f;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        qp_pkg::ST_DEV_ADR: begin
          if (bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            if (dev_match) begin
              state    <= qp_pkg::ST_ACK_DEV;
              rw       <= shreg[0];
              SDA_OE_N <= 1'b0;
            end else begin
              state <= qp_pkg::ST_IDLE;
            end
          end
        end
        qp_pkg::ST_ACK_DEV: begin
          if (rw) begin
            state    <= qp_pkg::ST_RD_DATA;
            out_byte <= rd_byte;
            SDA_OE_N <= rd_byte[7];
          end else begin
            state    <= qp_pkg::ST_REG_ADR;
            SDA_OE_N <= 1'b1;
          end
        end
        qp_pkg::ST_REG_ADR: begin
          if (bitcnt == 4'h8) begin
            state    <= qp_pkg::ST_ACK_REG;
            ptr      <= shreg;
            bitcnt   <= 4'h0;
            SDA_OE_N <= 1'b0;
          end
        end
        qp_pkg::ST_ACK_REG: begin
          state    <= qp_pkg::ST_WR_DATA;
          SDA_OE_N <= 1'b1;
        end
        qp_pkg::ST_WR_DATA: begin
          if (bitcnt == 4'h8) begin
            state    <= qp_pkg::ST_ACK_WR;
            bitcnt   <= 4'h0;
            SDA_OE_N <= 1'b0;
          end
        end
        qp_pkg::ST_ACK_WR: begin
          state    <= qp_pkg::ST_WR_DATA;
          ptr      <= ptr + 8'h01;
          SDA_OE_N <= 1'b1;
        end
        qp_pkg::ST_RD_DATA: begin
          if (bitcnt == 4'h8) begin
            state    <= qp_pkg::ST_RD_ACK;
            ptr      <= ptr + 8'h01;  // Early so the next byte reads the new pointer
            SDA_OE_N <= 1'b1;
          end else begin
            SDA_OE_N <= out_byte[3'h7 - bitcnt[2:0]];
          end
        end
        qp_pkg::ST_RD_ACK: begin
          if (master_nack) begin
            state    <= qp_pkg::ST_IDLE;
            SDA_OE_N <= 1'b1;
          end else begin
            state    <= qp_pkg::ST_RD_DATA;
            bitcnt   <= 4'h0;
            out_byte <= rd_byte;
            SDA_OE_N <= rd_byte[7];
          end
        end
        default: begin
          state <= qp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Line is never driven high; only the enable moves
  assign SDA_O = 1'b0;

  // Power-up recall of stored wiper values
  assign recall_pulse = ~recall_done & (recall_cnt == RCW'(RECALL_CYCLES - 1));

  always_ff @(posedge CLK) begin
    if (RST) begin
      recall_cnt  <= '0;
      recall_done <= 1'b0;
    end else if (!recall_done) begin
      recall_cnt  <= recall_cnt + RCW'(1);
      recall_done <= recall_pulse;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < qp_pkg::NUM_POTS; i++) begin
        wiper[i] <= qp_pkg::WIPER_RESET;
      end
    end else if (recall_pulse) begin
      for (int i = 0; i < qp_pkg::NUM_POTS; i++) begin
        wiper[i] <= store[i];
      end
    end else if (wr_wiper_ok) begin
      wiper[ptr[1:0]] <= shreg[6:0];
    end
  end

  // Serial writes win over a same-cycle register bus write
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < qp_pkg::NUM_POTS; i++) begin
        store[i] <= qp_pkg::STORE_INIT;
      end
    end else if (wr_wiper_ok && !volatile_target_select) begin
      store[ptr[1:0]] <= shreg[6:0];
    end else if (axi_wr && S_AXI_AWADDR[7:4] == qp_pkg::OFS_STORE0[7:4]
                 && S_AXI_AWADDR[1:0] == 2'h0 && S_AXI_WSTRB[0]) begin
      store[S_AXI_AWADDR[3:2]] <= S_AXI_WDATA[6:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      volatile_target_select     <= qp_pkg::ACR_VOL_RESET;
      pdn_bit <= qp_pkg::ACR_PDN_RESET;
    end else if (wr_acr_ok) begin
      volatile_target_select     <= shreg[qp_pkg::ACR_VOL_BIT];
      pdn_bit <= shreg[qp_pkg::ACR_PDN_BIT];
    end
  end

  // Self-timed store write, started only by a stop
  always_ff @(posedge CLK) begin
    if (RST) begin
      nv_dirty <= 1'b0;
      nv_write_pending      <= 1'b0;
      nv_cnt   <= '0;
    end else begin
      if (wr_wiper_ok && !volatile_target_select) begin
        nv_dirty <= 1'b1;
      end else if (stop_ev) begin
        nv_dirty <= 1'b0;
      end
      if (stop_ev && nv_dirty && !nv_write_pending) begin
        nv_write_pending    <= 1'b1;
        nv_cnt <= NVW'(NV_WRITE_CYCLES - 1);
      end else if (nv_write_pending) begin
        if (nv_cnt == '0) begin
          nv_write_pending <= 1'b0;
        end else begin
          nv_cnt <= nv_cnt - NVW'(1);
        end
      end
    end
  end

  // Analog switch controls; wiper contents survive power-down
  always_ff @(posedge CLK) begin
    if (RST) begin
      WIPER_TAP          <= {4{qp_pkg::WIPER_RESET}};
      HIGH_TERMINAL_OPEN <= 4'h0;
      WIPER_TO_LOW       <= 4'h0;
    end else begin
      WIPER_TAP          <= {wiper[3], wiper[2], wiper[1], wiper[0]};
      HIGH_TERMINAL_OPEN <= {4{pdn_active}};
      WIPER_TO_LOW       <= {4{pdn_active}};
    end
  end

  // AXI4-Lite slave: address and data taken together, one of each at a time
  assign S_AXI_AWREADY = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = S_AXI_AWREADY;
  assign axi_wr        = S_AXI_AWREADY;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign axi_rd        = S_AXI_ARVALID & S_AXI_ARREADY;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ser_en       <= qp_pkg::CTRL_EN_RESET;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= qp_pkg::RESP_OKAY;
    end else if (axi_wr) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= qp_pkg::RESP_OKAY;
      if (S_AXI_AWADDR == qp_pkg::OFS_CTRL) begin
        if (S_AXI_WSTRB[0]) begin
          ser_en <= S_AXI_WDATA[qp_pkg::CTRL_EN_BIT];
        end
      end else if (!(S_AXI_AWADDR[7:4] == qp_pkg::OFS_STORE0[7:4]
                     && S_AXI_AWADDR[1:0] == 2'h0)) begin
        S_AXI_BRESP <= qp_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[qp_pkg::ST_WIP_BIT]                   = nv_write_pending;
    status_word[qp_pkg::ST_PDN_BIT]                   = pdn_active;
    status_word[qp_pkg::ST_RECALL_BIT]                = recall_done;
    status_word[qp_pkg::ST_ACR_LSB +: 8]              = {volatile_target_select, pdn_bit, nv_write_pending, 5'h00};
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= qp_pkg::RESP_OKAY;
    end else if (axi_rd) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= qp_pkg::RESP_OKAY;
      S_AXI_RDATA  <= 32'h0000_0000;
      if (S_AXI_ARADDR[1:0] != 2'h0) begin
        S_AXI_RRESP <= qp_pkg::RESP_SLVERR;
      end else if (S_AXI_ARADDR[7:4] == qp_pkg::OFS_WIPER0[7:4]) begin
        S_AXI_RDATA <= {25'h0, wiper[S_AXI_ARADDR[3:2]]};
      end else if (S_AXI_ARADDR[7:4] == qp_pkg::OFS_STORE0[7:4]) begin
        S_AXI_RDATA <= {25'h0, store[S_AXI_ARADDR[3:2]]};
      end else if (S_AXI_ARADDR == qp_pkg::OFS_STATUS) begin
        S_AXI_RDATA <= status_word;
      end else if (S_AXI_ARADDR == qp_pkg::OFS_CTRL) begin
        S_AXI_RDATA <= {31'h0, ser_en};
      end else begin
        S_AXI_RRESP <= qp_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule

// *** testbench/qp_wiper_ctrl_properties.sv ***
// Port-level assertions for the wiper controller.
// Assumes one clock domain, synchronous active-high reset.
`timescale 1ns/1ps
module qp_wiper_ctrl_properties (
  input wire logic        CLK,                   // System clock
  input wire logic        RST,                   // Synchronous reset
  input wire logic        SCL_I,                 // Raw serial clock
  input wire logic        SDA_O,                 // Data drive value
  input wire logic        SDA_OE_N,              // Data pull-low enable
  input wire logic        POWER_DOWN_CONTROL_N,  // Power-down pin
  input wire logic [27:0] WIPER_TAP,             // Tap selects
  input wire logic [3:0]  HIGH_TERMINAL_OPEN,    // High ends open
  input wire logic [3:0]  WIPER_TO_LOW,          // Wipers to low end
  input wire logic        S_AXI_AWVALID,         // Write address valid
  input wire logic        S_AXI_WVALID,          // Write data valid
  input wire logic        S_AXI_BVALID,          // Write response valid
  input wire logic        S_AXI_BREADY,          // Write response ready
  input wire logic        S_AXI_ARVALID,         // Read address valid
  input wire logic        S_AXI_RVALID           // Read response valid
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  sda_low_only_a: assert property (SDA_O == 1'b0)
    else $error("Data line driven high");
  // Raw clock must already be low well before the filtered fall
  ack_after_fall_a: assert property ($fell(SDA_OE_N) |-> !SCL_I && !$past(SCL_I, 8))
    else $error("Data pulled low outside clock low phase");
  pd_pin_a: assert property (!POWER_DOWN_CONTROL_N |=> HIGH_TERMINAL_OPEN == 4'hF)
    else $error("Pin low did not enter power-down");
  pd_pair_a: assert property (WIPER_TO_LOW == HIGH_TERMINAL_OPEN)
    else $error("Wiper and high end disagree");
  wake_keep_a: assert property ($rose(POWER_DOWN_CONTROL_N) |=> $stable(WIPER_TAP))
    else $error("Wake changed a tap");
  reset_tap_a: assert property ($fell(RST) |->
    WIPER_TAP == {qp_pkg::NUM_POTS{qp_pkg::WIPER_RESET}})
    else $error("Taps not at reset value");
  recall_idle_a: assert property ($fell(RST) |-> SDA_OE_N [*8])
    else $error("Data pulled during recall");
  wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID |=> S_AXI_BVALID)
    else $error("Write response late");
  b_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("Write response held after handshake");
  rd_answer_a: assert property (S_AXI_ARVALID && !S_AXI_RVALID |=> S_AXI_RVALID)
    else $error("Read response late");
endmodule

bind qp_wiper_ctrl qp_wiper_ctrl_properties u_props (
  .CLK(CLK), .RST(RST), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N),
  .POWER_DOWN_CONTROL_N(POWER_DOWN_CONTROL_N), .WIPER_TAP(WIPER_TAP),
  .HIGH_TERMINAL_OPEN(HIGH_TERMINAL_OPEN), .WIPER_TO_LOW(WIPER_TO_LOW),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_RVALID(S_AXI_RVALID)
);

// *** testbench/qp_i2c_master.sv ***
// Behavioural serial bus master for the wiper controller.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/1ps
module qp_i2c_master #(
  parameter int H = 40  // Half bit period in clocks
) (
  input  wire logic clk,     // System clock
  output logic      scl,     // Clock line
  output logic      sda,     // 0 pulls low, 1 releases
  input  wire logic sda_in   // Resolved data wire
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only in the low phase, sampled mid-high
  task automatic bit_io(input logic b, input logic g, output logic r);
    sda <= b;
    tick(H);
    scl <= 1'b1;
    tick(H / 2);
    r = sda_in;
    if (g) begin
      scl <= 1'b0;
      tick(9);
      scl <= 1'b1;
    end
    tick(H / 2);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic start();
    sda <= 1'b1;
    tick(H);
    scl <= 1'b1;
    tick(H);
    sda <= 1'b0;
    tick(H);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda <= 1'b0;
    tick(H);
    scl <= 1'b1;
    tick(H);
    sda <= 1'b1;
    tick(H);
  endtask
  // Write: mack=1 releases for the slave's answer; read: d=FF, mack is ours
  task automatic xfer(input logic [7:0] d, input logic mack, input logic g,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], g && i == 7, r);
      q[i] = r;
    end
    bit_io(mack, 1'b0, r);
    ack = !r;
  endtask
endmodule

// *** testbench/qp_wiper_ctrl_tb_top.sv ***
// Bench for the wiper controller: register bus tasks and serial sequences.
// Assumes the serial master model; data wire has a pull-up.
`timescale 1ns/1ps
module qp_wiper_ctrl_tb_top;
  localparam int RECALL = 12;
  // Address bytes built from the design's identity nibble
  localparam logic [7:0] DEV_W = {qp_pkg::BUS_ID_NIBBLE, 3'h5, 1'b0};
  localparam logic [7:0] DEV_R = DEV_W | 8'h01;
  localparam logic [7:0] DEV_A = {qp_pkg::BUS_ID_NIBBLE, 3'h2, 1'b0};
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [2:0]       straps = 3'h5;
  logic             pdn_n = 1'b1;
  logic [7:0]       awaddr = 8'h00;
  logic [7:0]       araddr = 8'h00;
  logic [31:0]      wdata = 32'h0;
  logic             awvalid = 1'b0;
  logic             wvalid = 1'b0;
  logic             arvalid = 1'b0;
  wire logic        scl, sda_m, awready, wready, bvalid, arready, rvalid, oe_n;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [27:0] tap;
  wire logic [3:0]  hi_open, w_low;
  wire logic        sda_w = sda_m & oe_n;
  int               miscompares = 0;
  int               compares = 0;
  logic [31:0]      v;
  logic [7:0]       q;
  logic [1:0]       r;
  logic             k;
  always #2.5 clk = ~clk;
  qp_i2c_master m (.clk(clk), .scl(scl), .sda(sda_m), .sda_in(sda_w));
  qp_wiper_ctrl #(.NV_WRITE_CYCLES(4000), .RECALL_CYCLES(RECALL)) dut (
    .CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(), .SDA_OE_N(oe_n),
    .BUS_ADDR_STRAPS(straps), .POWER_DOWN_CONTROL_N(pdn_n), .WIPER_TAP(tap),
    .HIGH_TERMINAL_OPEN(hi_open), .WIPER_TO_LOW(w_low), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t acknowledge %b expected %b", $time, g, e);
    end
  endtask
  // Both ready lines held high, so every answer is taken at once
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_rd(a);
    chk(v, e);
    chk(32'(r), 32'(er));
  endtask
  task automatic sw(input logic [7:0] d, input logic e);
    m.xfer(d, 1'b1, 1'b0, q, k);
    chk_b(k, e);
  endtask
  task automatic sreg(input logic [7:0] ra, input logic [7:0] d);
    m.start();
    sw(DEV_W, 1'b1);
    sw(ra, 1'b1);
    sw(d, 1'b1);
    m.stop();
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_wr(qp_pkg::OFS_STORE0 + 8'h08, 32'h15);               // Preload before recall
    repeat (RECALL + 4) @(posedge clk);
    chk(32'(tap), 32'({7'h40, 7'h15, 7'h40, 7'h40}));
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'(4 * i), (i == 2) ? 32'h15 : 32'h40, qp_pkg::RESP_OKAY);
      rd_chk(8'(8'h10 + 4 * i), (i == 2) ? 32'h15 : 32'h40, qp_pkg::RESP_OKAY);
    end
    rd_chk(qp_pkg::OFS_STATUS, 32'h4004, qp_pkg::RESP_OKAY);
    rd_chk(qp_pkg::OFS_CTRL, 32'h1, qp_pkg::RESP_OKAY);
    rd_chk(8'h30, 32'h0, qp_pkg::RESP_SLVERR);
    axi_wr(qp_pkg::OFS_WIPER0, 32'h7);
    chk(32'(r), 32'(qp_pkg::RESP_SLVERR));
    sreg(8'h08, 8'hC0);
    m.start();
    sw(DEV_W, 1'b1);
    sw(8'h00, 1'b1);
    sw(8'h7F, 1'b1);
    sw(8'h00, 1'b1);
    sw(8'h33, 1'b1);
    sw(8'h01, 1'b1);
    m.stop();
    chk(32'(tap), 32'({7'h01, 7'h33, 7'h00, 7'h7F}));
    rd_chk(qp_pkg::OFS_STATUS, 32'hC004, qp_pkg::RESP_OKAY);
    rd_chk(qp_pkg::OFS_STORE0, 32'h40, qp_pkg::RESP_OKAY);
    m.start();
    sw(DEV_W, 1'b1);
    sw(8'h01, 1'b1);
    m.start();
    sw(DEV_R, 1'b1);
    m.xfer(8'hFF, 1'b0, 1'b0, q, k);
    chk(32'(q), 32'h00);
    m.xfer(8'hFF, 1'b1, 1'b0, q, k);
    chk(32'(q), 32'h33);
    m.stop();
    m.start();
    sw(DEV_A, 1'b0);
    sw(DEV_W, 1'b0);
    m.stop();
    straps <= 3'h2;
    m.start();
    sw(DEV_A, 1'b1);
    m.stop();
    straps <= 3'h5;
    m.start();
    m.xfer(DEV_W, 1'b1, 1'b1, q, k);
    chk_b(k, 1'b1);
    m.stop();
    axi_wr(qp_pkg::OFS_CTRL, 32'h0);                          // Slave disabled
    m.start();
    sw(DEV_W, 1'b0);
    m.stop();
    axi_wr(qp_pkg::OFS_CTRL, 32'h1);
    sreg(8'h08, 8'h40);
    sreg(8'h02, 8'h55);
    rd_chk(qp_pkg::OFS_STATUS, 32'h6005, qp_pkg::RESP_OKAY);
    sreg(8'h00, 8'h11);
    do axi_rd(qp_pkg::OFS_STATUS); while (v[0] !== 1'b0);
    chk(32'(tap), 32'({7'h01, 7'h55, 7'h00, 7'h7F}));
    rd_chk(qp_pkg::OFS_STORE0, 32'h40, qp_pkg::RESP_OKAY);
    rd_chk(qp_pkg::OFS_STORE0 + 8'h08, 32'h55, qp_pkg::RESP_OKAY);
    rd_chk(qp_pkg::OFS_STATUS, 32'h4004, qp_pkg::RESP_OKAY);
    pdn_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'({hi_open, w_low}), 32'hFF);
    rd_chk(qp_pkg::OFS_STATUS, 32'h4006, qp_pkg::RESP_OKAY);
    sreg(8'h08, 8'hC0);
    sreg(8'h03, 8'h22);
    pdn_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'({hi_open, w_low}), 32'h00);
    chk(32'(tap), 32'({7'h22, 7'h55, 7'h00, 7'h7F}));
    sreg(8'h08, 8'h80);
    chk(32'({hi_open, w_low}), 32'hFF);
    sreg(8'h08, 8'hC0);
    chk(32'({hi_open, w_low}), 32'h00);
    summarize();
  end
endmodule
